// *** inc/nptr_pkg.sv ***
// nptr_pkg: constants and types shared by the nand pointer page-read host controller
package nptr_pkg;
  // **************************************************************
  // command bytes
  // **************************************************************
  localparam logic [7:0] NPTR_CMD_MAIN = 8'h00;
  localparam logic [7:0] NPTR_CMD_HALF = 8'h01;
  localparam logic [7:0] NPTR_CMD_SPARE = 8'h50;
  localparam logic [7:0] NPTR_CMD_LOAD = 8'h80;
  localparam logic [7:0] NPTR_CMD_CONFIRM = 8'h10;
  localparam logic [7:0] NPTR_CMD_STATUS = 8'h70;
  // **************************************************************
  // timing, in ns and derived cycles
  // **************************************************************
  localparam int NPTR_CLK_NS = 10;
  localparam int NPTR_T_WP_NS = 25;
  localparam int NPTR_T_WH_NS = 20;
  localparam int NPTR_T_REA_NS = 30;
  localparam int NPTR_T_REH_NS = 15;
  localparam int NPTR_T_WB_NS = 100;
  localparam int NPTR_T_CEH_NS = 100;
  localparam int NPTR_SYNC_CYC = 2;
  localparam int NPTR_WP_CYC = (NPTR_T_WP_NS + NPTR_CLK_NS - 1) / NPTR_CLK_NS;
  localparam int NPTR_WH_CYC = (NPTR_T_WH_NS + NPTR_CLK_NS - 1) / NPTR_CLK_NS;
  localparam int NPTR_REA_CYC = (NPTR_T_REA_NS + NPTR_CLK_NS - 1) / NPTR_CLK_NS;
  localparam int NPTR_RE_LOW_CYC = NPTR_REA_CYC + NPTR_SYNC_CYC + 2;
  localparam int NPTR_REH_CYC = (NPTR_T_REH_NS + NPTR_CLK_NS - 1) / NPTR_CLK_NS;
  localparam int NPTR_WB_CYC = (NPTR_T_WB_NS + NPTR_CLK_NS - 1) / NPTR_CLK_NS + NPTR_SYNC_CYC;
  localparam int NPTR_CEH_CYC = (NPTR_T_CEH_NS + NPTR_CLK_NS - 1) / NPTR_CLK_NS;
  // **************************************************************
  // page geometry
  // **************************************************************
  localparam logic [9:0] NPTR_BASE_HALF = 10'h100;
  localparam logic [9:0] NPTR_BASE_SPARE8 = 10'h200;
  localparam logic [9:0] NPTR_BASE_SPARE16 = 10'h100;
  localparam logic [9:0] NPTR_LAST_MAIN8 = 10'h1ff;
  localparam logic [9:0] NPTR_LAST_ALL8 = 10'h20f;
  localparam logic [9:0] NPTR_LAST_MAIN16 = 10'h0ff;
  localparam logic [9:0] NPTR_LAST_ALL16 = 10'h107;
  localparam logic [7:0] NPTR_SPARE_MASK8 = 8'h0f;
  localparam logic [7:0] NPTR_SPARE_MASK16 = 8'h07;
  localparam logic [4:0] NPTR_LAST_PG_IN_BLK = 5'h1f;
  localparam int NPTR_PG_BITS = 5;
  // pointer area requested by the user
  typedef enum logic [1:0] {NPTR_AREA_A, NPTR_AREA_B, NPTR_AREA_C} nptr_area_t;
endpackage : nptr_pkg

// *** hdl/nptr_buf2.sv ***
// nptr_buf2: two-entry valid/ready buffer on the read data path
`timescale 1ns/100ps
`default_nettype none
module nptr_buf2 #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [1:0] cnt_r, cnt_nxt;
  logic [W-1:0] head_r, head_nxt, tail_r, tail_nxt;
  logic push, pop;

  if (W < 1) begin : g_chk
    $error("nptr_buf2: width must be positive");
  end

  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = head_r;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // next occupancy and entries
  always_comb begin
    cnt_nxt = cnt_r;
    head_nxt = head_r;
    tail_nxt = tail_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 2'h1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 2'h1;
    end
    if (pop) begin
      head_nxt = (cnt_r == 2'h2) ? tail_r : in_data;
    end else if (push && cnt_r == 2'h0) begin
      head_nxt = in_data;
    end
    if (push && ((cnt_r == 2'h1 && !pop) || (cnt_r == 2'h2))) begin
      tail_nxt = in_data;
    end
  end

  // registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_r <= 2'h0;
      head_r <= '0;
      tail_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      head_r <= head_nxt;
      tail_r <= tail_nxt;
    end
  end
endmodule : nptr_buf2
`default_nettype wire

// *** hdl/nptr_host.sv ***
// nptr_host: host-side controller driving the nand flash pins for pointer, read and program
`timescale 1ns/100ps
`default_nettype none
module nptr_host #(
  parameter int WIDE = 0,
  parameter bit SEQ_ROW = 1'b1,
  parameter bit SPARE_PIN_LOW = 1'b1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // command request
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_prog,
  input wire nptr_pkg::nptr_area_t cmd_area,
  input wire logic [7:0] cmd_col,
  input wire logic [15:0] cmd_page,
  input wire logic [9:0] cmd_len,
  // command outcome
  output logic cmd_done,
  output logic cmd_err,
  output logic prog_fail_r,
  output logic [10:0] bad_blk_r,
  output logic bad_vld_r,
  // write data
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [15:0] wr_data,
  // read data
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [15:0] rd_data,
  // flash pins
  output logic ce_n_r,
  output logic cle_r,
  output logic ale_r,
  output logic we_n_r,
  output logic re_n_r,
  output logic [15:0] io_out_r,
  output logic io_oe_n_r,
  input wire logic [15:0] io_in,
  input wire logic rb
);
  import nptr_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_PTR, S_LOAD, S_ADDR, S_WGET, S_WDATA, S_CONF, S_TWB, S_BUSY,
    S_STAT, S_RGAP, S_RD, S_RESTORE, S_CEH
  } nptr_st_t;

  localparam logic [15:0] DMASK = (WIDE == 1) ? 16'hffff : 16'h00ff;

  if (WIDE != 0 && WIDE != 1) begin : g_chk
    $error("nptr_host: WIDE must be 0 (byte) or 1 (word)");
  end

  // **************************************************************
  // pin synchronisers
  // **************************************************************
  logic [15:0] io_m_r, io_s_r;
  logic rb_m_r, rb_s_r;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      io_m_r <= 16'h0000;
      io_s_r <= 16'h0000;
      rb_m_r <= 1'b0;
      rb_s_r <= 1'b0;
    end else begin
      io_m_r <= io_in;
      io_s_r <= io_m_r;
      rb_m_r <= rb;
      rb_s_r <= rb_m_r;
    end
  end

  // **************************************************************
  // sequencer state
  // **************************************************************
  nptr_st_t st_r, st_nxt;
  logic ph_r, ph_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [1:0] acnt_r, acnt_nxt;
  logic prog_r, prog_nxt, stat_r, stat_nxt;
  nptr_area_t area_r, area_nxt;
  logic [7:0] col_r, col_nxt;
  logic [9:0] pos_r, pos_nxt, len_r, len_nxt, wcnt_r, wcnt_nxt, last_col;
  logic [15:0] page_r, page_nxt, wdat_r, wdat_nxt;
  logic fail_nxt, bad_v_nxt;
  logic [10:0] bad_b_nxt;
  logic reject, wr_end, rd_low_end, rd_end, buf_in_valid, buf_in_ready;
  logic [7:0] ptr_cmd, mask_col;
  logic ce_n_nxt, cle_nxt, ale_nxt, we_n_nxt, re_n_nxt, oe_n_nxt;
  logic [15:0] io_nxt;

  // pointer command and spare start mask for the latched area
  always_comb begin
    ptr_cmd = NPTR_CMD_MAIN;
    mask_col = col_r;
    if (area_r == NPTR_AREA_B) begin
      ptr_cmd = NPTR_CMD_HALF;
    end else if (area_r == NPTR_AREA_C) begin
      ptr_cmd = NPTR_CMD_SPARE;
      mask_col = col_r & ((WIDE == 1) ? NPTR_SPARE_MASK16 : NPTR_SPARE_MASK8);
    end
    if (WIDE == 1) begin
      last_col = (area_r == NPTR_AREA_C || SPARE_PIN_LOW) ? NPTR_LAST_ALL16 : NPTR_LAST_MAIN16;
    end else begin
      last_col = (area_r == NPTR_AREA_C || SPARE_PIN_LOW) ? NPTR_LAST_ALL8 : NPTR_LAST_MAIN8;
    end
  end

  // refused requests: half pointer on word part, empty program, program to a known bad block
  assign reject = (WIDE == 1 && cmd_area == NPTR_AREA_B) || (cmd_prog && cmd_len == 10'h000)
    || (cmd_prog && bad_vld_r && cmd_page[15:NPTR_PG_BITS] == bad_blk_r);
  assign cmd_ready = (st_r == S_IDLE);
  assign cmd_err = (st_r == S_IDLE) && cmd_valid && reject;
  assign cmd_done = (st_r == S_CEH) && (cnt_r == 4'(NPTR_CEH_CYC - 1));
  assign wr_ready = (st_r == S_WGET);
  assign wr_end = ph_r && (cnt_r == 4'(NPTR_WH_CYC - 1));
  assign rd_low_end = !ph_r && (cnt_r == 4'(NPTR_RE_LOW_CYC - 1));
  assign rd_end = ph_r && (cnt_r == 4'(NPTR_REH_CYC - 1));
  assign buf_in_valid = (st_r == S_RD) && rd_low_end && !stat_r;

  // next-state logic of the sequencer
  always_comb begin
    st_nxt = st_r;
    ph_nxt = ph_r;
    cnt_nxt = cnt_r + 4'h1;
    acnt_nxt = acnt_r;
    prog_nxt = prog_r;
    stat_nxt = stat_r;
    area_nxt = area_r;
    col_nxt = col_r;
    pos_nxt = pos_r;
    len_nxt = len_r;
    wcnt_nxt = wcnt_r;
    page_nxt = page_r;
    wdat_nxt = wdat_r;
    fail_nxt = prog_fail_r;
    bad_v_nxt = bad_vld_r;
    bad_b_nxt = bad_blk_r;
    case (st_r)
      S_IDLE: begin
        cnt_nxt = 4'h0;
        ph_nxt = 1'b0;
        acnt_nxt = 2'h0;
        wcnt_nxt = 10'h000;
        stat_nxt = 1'b0;
        if (cmd_valid && !reject) begin
          prog_nxt = cmd_prog;
          area_nxt = cmd_area;
          col_nxt = cmd_col;
          page_nxt = cmd_page;
          len_nxt = cmd_len;
          fail_nxt = 1'b0;
          pos_nxt = {2'b00, cmd_col};
          if (cmd_area == NPTR_AREA_B) begin
            pos_nxt = NPTR_BASE_HALF + {2'b00, cmd_col};
          end else if (cmd_area == NPTR_AREA_C) begin
            pos_nxt = ((WIDE == 1) ? NPTR_BASE_SPARE16 : NPTR_BASE_SPARE8)
              + {2'b00, cmd_col & ((WIDE == 1) ? NPTR_SPARE_MASK16 : NPTR_SPARE_MASK8)};
          end
          st_nxt = S_PTR;
        end
      end
      S_PTR, S_LOAD, S_ADDR, S_WDATA, S_CONF, S_STAT, S_RESTORE: begin
        if (!ph_r && cnt_r == 4'(NPTR_WP_CYC - 1)) begin
          ph_nxt = 1'b1;
          cnt_nxt = 4'h0;
        end else if (wr_end) begin
          ph_nxt = 1'b0;
          cnt_nxt = 4'h0;
          case (st_r)
            S_PTR: st_nxt = prog_r ? S_LOAD : S_ADDR;
            S_LOAD: st_nxt = S_ADDR;
            S_ADDR: begin
              acnt_nxt = acnt_r + 2'h1;
              if (acnt_r == 2'h2) begin
                st_nxt = prog_r ? S_WGET : S_TWB;
              end
            end
            S_WDATA: st_nxt = (wcnt_r == len_r) ? S_CONF : S_WGET;
            S_CONF: st_nxt = S_TWB;
            S_STAT: begin
              stat_nxt = 1'b1;
              st_nxt = S_TWB;
            end
            default: st_nxt = S_CEH;
          endcase
        end
      end
      S_WGET: begin
        cnt_nxt = 4'h0;
        if (wr_valid) begin
          wdat_nxt = wr_data & DMASK;
          wcnt_nxt = wcnt_r + 10'h001;
          st_nxt = S_WDATA;
        end
      end
      S_TWB: begin
        if (cnt_r == 4'(NPTR_WB_CYC - 1)) begin
          st_nxt = S_BUSY;
        end
      end
      S_BUSY: begin
        cnt_nxt = 4'h0;
        if (rb_s_r) begin
          st_nxt = (prog_r && !stat_r) ? S_STAT : S_RGAP;
        end
      end
      S_RGAP: begin
        cnt_nxt = 4'h0;
        if (buf_in_ready) begin
          st_nxt = S_RD;
        end
      end
      S_RD: begin
        if (rd_low_end) begin
          ph_nxt = 1'b1;
          cnt_nxt = 4'h0;
          if (stat_r && io_s_r[0]) begin
            fail_nxt = 1'b1;
            bad_v_nxt = 1'b1;
            bad_b_nxt = page_r[15:NPTR_PG_BITS];
          end
        end else if (rd_end) begin
          ph_nxt = 1'b0;
          cnt_nxt = 4'h0;
          wcnt_nxt = wcnt_r + 10'h001;
          pos_nxt = pos_r + 10'h001;
          if (stat_r || wcnt_r + 10'h001 == len_r) begin
            st_nxt = (area_r == NPTR_AREA_C) ? S_RESTORE : S_CEH;
          end else if (pos_r != last_col) begin
            st_nxt = S_RGAP;
          end else if (SEQ_ROW && page_r[NPTR_PG_BITS-1:0] != NPTR_LAST_PG_IN_BLK) begin
            page_nxt = page_r + 16'h0001;
            pos_nxt = (area_r == NPTR_AREA_C) ? ((WIDE == 1) ? NPTR_BASE_SPARE16 : NPTR_BASE_SPARE8)
              : 10'h000;
            st_nxt = S_TWB;
          end else begin
            st_nxt = (area_r == NPTR_AREA_C) ? S_RESTORE : S_CEH;
          end
        end
      end
      S_CEH: begin
        if (cmd_done) begin
          st_nxt = S_IDLE;
        end
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  // pin values for the coming cycle, from the next state
  always_comb begin
    ce_n_nxt = (st_nxt == S_IDLE) || (st_nxt == S_CEH);
    cle_nxt = (st_nxt == S_PTR) || (st_nxt == S_LOAD) || (st_nxt == S_CONF) || (st_nxt == S_STAT)
      || (st_nxt == S_RESTORE);
    ale_nxt = (st_nxt == S_ADDR);
    oe_n_nxt = !(cle_nxt || ale_nxt || st_nxt == S_WDATA);
    we_n_nxt = oe_n_nxt || ph_nxt;
    re_n_nxt = !(st_nxt == S_RD && !ph_nxt);
    case (st_nxt)
      S_PTR: io_nxt = {8'h00, ptr_cmd};
      S_LOAD: io_nxt = {8'h00, NPTR_CMD_LOAD};
      S_CONF: io_nxt = {8'h00, NPTR_CMD_CONFIRM};
      S_STAT: io_nxt = {8'h00, NPTR_CMD_STATUS};
      S_RESTORE: io_nxt = {8'h00, NPTR_CMD_MAIN};
      S_WDATA: io_nxt = wdat_nxt;
      S_ADDR: begin
        case (acnt_nxt)
          2'h0: io_nxt = {8'h00, mask_col};
          2'h1: io_nxt = {8'h00, page_r[7:0]};
          default: io_nxt = {8'h00, page_r[15:8]};
        endcase
      end
      default: io_nxt = 16'h0000;
    endcase
  end

  // sequencer and pin registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r <= S_IDLE;
      ph_r <= 1'b0;
      cnt_r <= 4'h0;
      acnt_r <= 2'h0;
      prog_r <= 1'b0;
      stat_r <= 1'b0;
      area_r <= NPTR_AREA_A;
      col_r <= 8'h00;
      pos_r <= 10'h000;
      len_r <= 10'h000;
      wcnt_r <= 10'h000;
      page_r <= 16'h0000;
      wdat_r <= 16'h0000;
      prog_fail_r <= 1'b0;
      bad_vld_r <= 1'b0;
      bad_blk_r <= 11'h000;
      ce_n_r <= 1'b1;
      cle_r <= 1'b0;
      ale_r <= 1'b0;
      we_n_r <= 1'b1;
      re_n_r <= 1'b1;
      io_out_r <= 16'h0000;
      io_oe_n_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      ph_r <= ph_nxt;
      cnt_r <= cnt_nxt;
      acnt_r <= acnt_nxt;
      prog_r <= prog_nxt;
      stat_r <= stat_nxt;
      area_r <= area_nxt;
      col_r <= col_nxt;
      pos_r <= pos_nxt;
      len_r <= len_nxt;
      wcnt_r <= wcnt_nxt;
      page_r <= page_nxt;
      wdat_r <= wdat_nxt;
      prog_fail_r <= fail_nxt;
      bad_vld_r <= bad_v_nxt;
      bad_blk_r <= bad_b_nxt;
      ce_n_r <= ce_n_nxt;
      cle_r <= cle_nxt;
      ale_r <= ale_nxt;
      we_n_r <= we_n_nxt;
      re_n_r <= re_n_nxt;
      io_out_r <= io_nxt;
      io_oe_n_r <= oe_n_nxt;
    end
  end

  // **************************************************************
  // read data buffer
  // **************************************************************
  nptr_buf2 #(.W(16)) u_buf (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(io_s_r & DMASK),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  // **************************************************************
  // checks
  // **************************************************************
  logic [7:0] prev_cmd_r;
  // last command byte completed on the bus
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prev_cmd_r <= 8'h00;
    end else if (cle_r && !we_n_r && we_n_nxt) begin
      prev_cmd_r <= io_out_r[7:0];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  io_hi_zero_a: assert property ((cle_r || ale_r) && !io_oe_n_r |-> io_out_r[15:8] == 8'h00)
    else $error("upper io not zero in command or address cycle");
  half_load_a: assert property ($fell(we_n_r) && cle_r && io_out_r[7:0] == NPTR_CMD_LOAD
    && area_r == NPTR_AREA_B |-> prev_cmd_r == NPTR_CMD_HALF)
    else $error("load not directly after half pointer");
  ptr_load_a: assert property ($fell(we_n_r) && cle_r && io_out_r[7:0] == NPTR_CMD_LOAD
    |-> prev_cmd_r == ptr_cmd)
    else $error("load without matching pointer");
  addr_three_a: assert property ($fell(re_n_r) && !stat_r |-> acnt_r == 2'h3)
    else $error("read strobe before three address cycles");
  ready_strobe_a: assert property ($fell(re_n_r) |-> rb_s_r && $past(rb_s_r))
    else $error("read strobe while busy");
  confirm_data_a: assert property ($fell(we_n_r) && cle_r && io_out_r[7:0] == NPTR_CMD_CONFIRM
    |-> wcnt_r == len_r && len_r != 10'h000)
    else $error("confirm without loaded data");
  spare_addr_a: assert property ($fell(we_n_r) && ale_r && acnt_r == 2'h0 && area_r == NPTR_AREA_C
    |-> (io_out_r[7:0] & ~((WIDE == 1) ? NPTR_SPARE_MASK16 : NPTR_SPARE_MASK8)) == 8'h00)
    else $error("spare start address has high bits set");
  restore_main_a: assert property ($rose(ce_n_r) && area_r == NPTR_AREA_C |-> prev_cmd_r == NPTR_CMD_MAIN)
    else $error("spare read ended without main pointer");
  seq_block_a: assert property (!ce_n_r && !$past(ce_n_r) && $changed(page_r)
    |-> page_r == $past(page_r) + 16'h0001 && page_r[NPTR_PG_BITS-1:0] != '0)
    else $error("sequential row read crosses block");
  we_width_a: assert property ($fell(we_n_r) |-> (!we_n_r)[*3] ##1 we_n_r)
    else $error("write strobe width wrong");
  re_width_a: assert property ($fell(re_n_r) |-> (!re_n_r)[*7] ##1 re_n_r)
    else $error("read strobe width wrong");
endmodule : nptr_host
`default_nettype wire

// *** dv/nptr_flash_model.sv ***
// nptr_flash_model: behavioural nand flash answering the host controller pins
`timescale 1ns/100ps
`default_nettype none
module nptr_flash_model #(
  parameter int BUSY_NS = 2000
) (
  // control pins
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  // data and ready
  input wire logic [15:0] io,
  output logic [15:0] io_drv,
  output logic rb,
  // test hooks
  input wire logic fail,
  output logic pin_bad
);
  // ************************************************
  // pointer, address and page state
  // ************************************************
  logic [9:0] base = 10'h000;
  logic [9:0] col = 10'h000;
  logic [15:0] page = 16'h0000;
  logic [1:0] acnt = 2'h0;
  logic prog = 1'b0;
  logic stat = 1'b0;
  logic [7:0] mem [logic [25:0]];
  int busy_gen = 0;
  event go;
  initial begin
    io_drv = 16'h0000;
    rb = 1'b1;
    pin_bad = 1'b0;
  end
  // array busy while a page moves in or a program runs; a new start restarts the wait
  always @(go) begin
    busy_gen = busy_gen + 1;
    rb = 1'b0;
    fork
      begin
        automatic int g = busy_gen;
        #(BUSY_NS);
        if (g == busy_gen) rb = 1'b1;
      end
    join_none
  end
  // command, address and data latch on write strobe rise
  always @(posedge we_n) begin
    if (!ce_n && cle) begin
      pin_bad = pin_bad | (io[15:8] != 8'h00);
      acnt = 2'h0;
      case (io[7:0])
        8'h00: base = 10'h000;
        8'h01: base = 10'h100;
        8'h50: base = 10'h200;
        8'h80: prog = 1'b1;
        8'h10: if (prog) -> go;
        default: ;
      endcase
      stat = (io[7:0] == 8'h70);
      if (io[7:0] == 8'h10 && base == 10'h100) base = 10'h000;
      if (io[7:0] == 8'h10) prog = 1'b0;
    end else if (!ce_n && ale) begin
      pin_bad = pin_bad | (io[15:8] != 8'h00);
      if (acnt == 2'h0) col = base + ((base == 10'h200) ? {6'h00, io[3:0]} : {2'h0, io[7:0]});
      if (acnt == 2'h1) page[7:0] = io[7:0];
      if (acnt == 2'h2) page[15:8] = io[7:0];
      if (acnt == 2'h2 && !prog) -> go;
      if (acnt == 2'h2 && !prog && base == 10'h100) base = 10'h000;
      acnt = acnt + 2'h1;
    end else if (!cle && !ale && prog) begin
      mem[{page, col}] = io[7:0];
      col = col + 10'h001;
    end
  end
  // next word on read strobe fall, walking on to the next page at the end
  always @(negedge re_n) begin
    if (stat) begin
      io_drv = {8'h00, 2'h3, 5'h00, fail};
    end else begin
      io_drv = {8'h00, mem.exists({page, col}) ? mem[{page, col}] : page[7:0] ^ col[7:0] ^ {6'h00, col[9:8]}};
      if (col == 10'h20f) begin
        col = (base == 10'h200) ? 10'h200 : 10'h000;
        page = page + 16'h0001;
        -> go;
      end else begin
        col = col + 10'h001;
      end
    end
  end
  // released bus shows the inverse of the last word after hold time
  always @(posedge re_n) #15 io_drv = ~io_drv;
endmodule : nptr_flash_model
`default_nettype wire

// *** dv/nptr_host_test.sv ***
// nptr_host_test: self-checking bench for the nand pointer page-read host
`timescale 1ns/100ps
`default_nettype none
module nptr_host_test;
  import nptr_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, cmd_prog = 1'b0, wr_valid = 1'b0, rd_ready = 1'b1, fail = 1'b0;
  logic cmd_ready, cmd_done, cmd_err, prog_fail_r, bad_vld_r, wr_ready, rd_valid, rb, pin_bad;
  logic ce_n_r, cle_r, ale_r, we_n_r, re_n_r, io_oe_n_r;
  nptr_area_t cmd_area = NPTR_AREA_A;
  logic [7:0] cmd_col = 8'h00;
  logic [9:0] cmd_len = 10'h000;
  logic [10:0] bad_blk_r;
  logic [15:0] cmd_page = 16'h0000, wr_data = 16'h0000, rd_data, io_out_r, io_drv, io_in;
  int err_total = 0;
  int checks = 0;
  logic [15:0] got[$];
  logic [15:0] wq[$];
  always #5 mclk = ~mclk;
  // host owns the bus while its enable is low
  assign io_in = io_oe_n_r ? io_drv : io_out_r;
  nptr_host #(.WIDE(0), .SEQ_ROW(1'b1), .SPARE_PIN_LOW(1'b1)) nptr_host_i (.mclk, .rst_n, .cmd_valid, .cmd_ready,
    .cmd_prog, .cmd_area, .cmd_col, .cmd_page, .cmd_len, .cmd_done, .cmd_err, .prog_fail_r, .bad_blk_r, .bad_vld_r,
    .wr_valid, .wr_ready, .wr_data, .rd_valid, .rd_ready, .rd_data, .ce_n_r, .cle_r, .ale_r, .we_n_r, .re_n_r,
    .io_out_r, .io_oe_n_r, .io_in, .rb);
  nptr_flash_model nptr_flash_model_i (.ce_n(ce_n_r), .cle(cle_r), .ale(ale_r), .we_n(we_n_r), .re_n(re_n_r),
    .io(io_in), .io_drv, .rb, .fail, .pin_bad);
  // ************************************************
  // compare, close and bus tasks
  // ************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    checks++;
    if (seen !== want) begin
      err_total++;
      $display("ERROR %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk
  task automatic close_out();
    if (err_total == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  // one request, then traffic until done and the read buffer is empty
  task automatic op(input logic prog, input nptr_area_t area, input logic [7:0] col, input logic [15:0] page,
      input logic [9:0] len, input int stall, output logic refused);
    int k;
    logic dn;
    logic wt;
    dn = 1'b0;
    k = 0;
    got.delete();
    @(posedge mclk);
    #1;
    cmd_valid = 1'b1;
    cmd_prog = prog;
    cmd_area = area;
    cmd_col = col;
    cmd_page = page;
    cmd_len = len;
    do begin
      @(negedge mclk);
      refused = cmd_err;
      k++;
    end while (cmd_ready !== 1'b1 && k < 100);
    if (cmd_ready !== 1'b1) begin
      chk(16'h0000, 16'h0001);
      close_out();
    end
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    if (refused === 1'b1) return;
    for (k = 0; k < 30000 && !(dn && rd_valid !== 1'b1); k++) begin
      rd_ready = (stall == 0) || (k % stall == 0);
      wr_valid = (wq.size() != 0);
      wr_data = (wq.size() != 0) ? wq[0] : 16'h0000;
      @(negedge mclk);
      if (rd_valid === 1'b1 && rd_ready) got.push_back(rd_data);
      wt = wr_valid && wr_ready === 1'b1;
      dn = dn || cmd_done === 1'b1;
      @(posedge mclk);
      #1;
      if (wt) void'(wq.pop_front());
    end
    if (k >= 30000) begin
      chk(16'h0000, 16'h0001);
      close_out();
    end
  endtask : op
  // read and compare against the page walk worked out here
  task automatic rd_chk(input nptr_area_t area, input logic [7:0] col, input logic [15:0] page,
      input logic [9:0] len, input int stall);
    logic r;
    logic stop;
    logic [9:0] c;
    logic [15:0] p;
    int n;
    p = page;
    stop = 1'b0;
    c = (area == NPTR_AREA_C) ? 10'h200 + {6'h00, col[3:0]} : (area == NPTR_AREA_B) ? 10'h100 + {2'h0, col} : {2'h0, col};
    op(1'b0, area, col, page, len, stall, r);
    chk({15'h0000, r}, 16'h0000);
    for (n = 0; n < len && !stop; n++) begin
      chk(got[n], {8'h00, p[7:0] ^ c[7:0] ^ {6'h00, c[9:8]}});
      stop = (c == 10'h20f) && (p[4:0] == 5'h1f);
      if (c == 10'h20f) begin
        c = (area == NPTR_AREA_C) ? 10'h200 : 10'h000;
        p = p + 16'h0001;
      end else begin
        c = c + 10'h001;
      end
    end
    chk(16'(got.size()), 16'(n));
  endtask : rd_chk
  // ************************************************
  // scenarios
  // ************************************************
  task automatic sc_reads();
    rd_chk(NPTR_AREA_A, 8'h05, 16'h0021, 10'h004, 0);
    rd_chk(NPTR_AREA_B, 8'h10, 16'h0021, 10'h003, 0);
    rd_chk(NPTR_AREA_A, 8'hff, 16'h0022, 10'h002, 0);
    rd_chk(NPTR_AREA_C, 8'h13, 16'h0023, 10'h006, 8);
    chk({6'h00, nptr_flash_model_i.base}, 16'h0000);
  endtask : sc_reads
  task automatic sc_seq();
    rd_chk(NPTR_AREA_B, 8'hfe, 16'h0040, 10'h014, 0);
    rd_chk(NPTR_AREA_C, 8'h0e, 16'h005e, 10'h004, 2);
    rd_chk(NPTR_AREA_C, 8'h0f, 16'h007f, 10'h005, 0);
  endtask : sc_seq
  task automatic sc_prog();
    logic r;
    wq = '{16'h00a5, 16'h003c};
    op(1'b1, NPTR_AREA_A, 8'h02, 16'h0085, 10'h002, 0, r);
    chk({8'h00, nptr_flash_model_i.mem[{16'h0085, 10'h002}]}, 16'h00a5);
    chk({8'h00, nptr_flash_model_i.mem[{16'h0085, 10'h003}]}, 16'h003c);
    chk({15'h0000, prog_fail_r}, 16'h0000);
    fail = 1'b1;
    wq = '{16'h0077};
    op(1'b1, NPTR_AREA_B, 8'h04, 16'h0086, 10'h001, 0, r);
    chk({8'h00, nptr_flash_model_i.mem[{16'h0086, 10'h104}]}, 16'h0077);
    chk({3'h0, prog_fail_r, bad_vld_r, bad_blk_r}, 16'h1804);
    fail = 1'b0;
    wq = '{16'h0011};
    op(1'b1, NPTR_AREA_A, 8'h00, 16'h0090, 10'h001, 0, r);
    chk({15'h0000, r}, 16'h0001);
    op(1'b1, NPTR_AREA_A, 8'h00, 16'h0100, 10'h000, 0, r);
    chk({15'h0000, r}, 16'h0001);
    chk({15'h0000, pin_bad}, 16'h0000);
    wq.delete();
  endtask : sc_prog
  // main sequence
  initial begin
    repeat (8) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    sc_reads();
    sc_seq();
    sc_prog();
    close_out();
  end
endmodule : nptr_host_test
`default_nettype wire
